// ### common/pid_pkg.sv
// Purpose: Shared constants and types for pair identification and deskew
// Assumes: 100 MHz clock, up to three pairs
// Notes: Register offsets are byte addresses on the plain register port
package pid_pkg;
	// ----------------------------------------
	// Pairs and indicator bits
	// ----------------------------------------
	localparam int MAX_PAIRS = 3;
	localparam int IND_W = 3;
	localparam logic [2:0] MATCH_LAST = 3'h5;
	localparam logic [2:0] ALL_ONES = 3'h7;
	localparam logic [2:0] TWO_PAIR_MASK = 3'h3;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int SKEW_US = 60;
	localparam int CLK_MHZ = 100;
	localparam int SKEW_CYC = SKEW_US * CLK_MHZ;
	localparam int SKEW_W = 16;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam int ADDR_W = 4;
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_PAIRNUM = 4'h4;
	localparam logic [3:0] REG_STATUS = 4'h8;
	localparam int CTRL_EN = 0;
	localparam int CTRL_LINE = 1;
	localparam int CTRL_THREE = 2;
	localparam logic [2:0] CTRL_RST = 3'h0;
	localparam logic [5:0] PAIRNUM_RST = 6'h39;
	localparam int ST_DONE = 0;
	localparam int ST_ONES = 3;
	localparam int ST_XPAR = 6;
	localparam int ST_SKEW = 7;

	typedef enum logic [1:0] {PS_WAIT, PS_HUNT, PS_DONE} pid_pair_state_t;
endpackage

// ### hw/pid_deskew.sv
// What this block does
// - Deskew buffer aligns frames across pairs; tolerates 60 us skew.
// - Line side: each transceiver gets pair number 1..3 or 1..2.
// - Customer side takes no preset number; derives it from received bits.
// - Line side drives its pair pattern once transceiver is active.
// - Three pairs: pattern for pair m is one-hot, bit m set.
// - Two pairs: two one-hot bits, pair 1 is 1,0, pair 2 is 0,1.
// - Customer side sends all ones until that pair is identified.
// - Customer side examines received bits only while transceiver is active.
// - Identified after six consecutive equal valid patterns not claimed elsewhere.
// - Customer side echoes recognised pattern for rest of activation period.
// - Customer side maps data by pattern once all pairs identified.
// - Line side monitors received bits, first expecting all ones.
// - Line side acknowledges pair after six consecutive own-pattern frames.
// - Line side goes transparent only after all installed pairs acknowledged.
// - Identification runs per installed pair, two or three pair systems only.
//
// Purpose: Pair identification handshake and lane deskew for 2/3 pairs
// Assumes: Frame strobes and data come from logic on the same clock
// Notes: One role per instance, chosen by the line-side control bit
`timescale 1ns/1ps

module pid_fifo #(
	parameter int W = 8,
	parameter int D = 8
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic flush,
	input wire logic in_valid,
	input wire logic [W-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [W-1:0] out_data,
	input wire logic out_ready
);
	localparam int AW = $clog2(D);
	localparam logic [AW:0] FULL = (AW+1)'(D);
	localparam logic [AW-1:0] LAST = AW'(D - 1);
	logic [W-1:0] mem [D];
	logic [AW-1:0] wp, rp;
	logic [AW:0] fill;
	logic push, pop;

	assign in_ready = fill != FULL;
	assign out_valid = fill != '0;
	assign out_data = mem[rp];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wp] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wp <= '0;
			rp <= '0;
			fill <= '0;
		end else if (flush) begin
			wp <= '0;
			rp <= '0;
			fill <= '0;
		end else begin
			if (push) begin
				wp <= (wp == LAST) ? '0 : wp + 1'b1;
			end
			if (pop) begin
				rp <= (rp == LAST) ? '0 : rp + 1'b1;
			end
			fill <= fill + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // pid_fifo

module pid_deskew #(
	parameter int DATA_W = 8,
	parameter int FIFO_DEPTH = 8,
	parameter int MAX_SKEW_CYC = pid_pkg::SKEW_CYC
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [pid_pkg::ADDR_W-1:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	input wire logic [pid_pkg::MAX_PAIRS-1:0] active,
	input wire logic [pid_pkg::MAX_PAIRS-1:0] frm,
	input wire logic [pid_pkg::MAX_PAIRS-1:0][pid_pkg::IND_W-1:0] rx_ind,
	output logic [pid_pkg::MAX_PAIRS-1:0][pid_pkg::IND_W-1:0] tx_ind,
	input wire logic [pid_pkg::MAX_PAIRS-1:0][DATA_W-1:0] rx_data,
	input wire logic [pid_pkg::MAX_PAIRS-1:0] rx_valid,
	output logic [pid_pkg::MAX_PAIRS-1:0] rx_ready,
	output logic [pid_pkg::MAX_PAIRS*DATA_W-1:0] core_data,
	output logic core_valid,
	input wire logic core_ready,
	output logic transparent
);
	import pid_pkg::*;
	localparam int NP = MAX_PAIRS;
	localparam logic [SKEW_W-1:0] SKEW_LAST = SKEW_W'(MAX_SKEW_CYC - 1);

	logic [2:0] ctrl;
	logic [5:0] pairnum;
	logic skew_err;
	logic [SKEW_W-1:0] skew_cnt;
	pid_pair_state_t st [NP];
	logic [2:0] cnt [NP];
	logic [IND_W-1:0] cand [NP];
	logic [IND_W-1:0] pat [NP];
	logic [NP-1:0] ones_seen;
	logic [IND_W-1:0] own [NP];
	logic [NP-1:0] match, go, act, done, fv, fpop, fr;
	logic [NP-1:0][DATA_W-1:0] fdata;
	logic line, all_v, some_v, pop;
	logic [IND_W-1:0] inst;

	// ----------------------------------------
	// Pattern helpers
	// ----------------------------------------
	function automatic logic [IND_W-1:0] num2pat(input logic [1:0] n);
		logic [IND_W-1:0] p;
		p = '0;
		if (n != 2'h0) begin
			p[n - 2'h1] = 1'b1;
		end
		return p;
	endfunction

	function automatic logic pat_ok(input logic [IND_W-1:0] x, input logic [IND_W-1:0] m);
		return (x != '0) && ((x & (x - 1'b1)) == '0) && ((x & ~m) == '0);
	endfunction

	assign line = ctrl[CTRL_LINE];
	assign inst = ctrl[CTRL_THREE] ? ALL_ONES : TWO_PAIR_MASK;
	assign act = active & inst & {NP{ctrl[CTRL_EN]}};

	always_comb begin
		for (int p = 0; p < NP; p++) begin
			own[p] = num2pat(pairnum[2*p +: 2]) & inst;
			done[p] = st[p] == PS_DONE;
			if (line) begin
				match[p] = (own[p] != '0) && (rx_ind[p] == own[p]);
			end else begin
				match[p] = pat_ok(rx_ind[p], inst) && (rx_ind[p] == cand[p]);
			end
		end
	end

	// ----------------------------------------
	// Consecutive frame counting
	// ----------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			for (int p = 0; p < NP; p++) begin
				cnt[p] <= '0;
				cand[p] <= '0;
			end
		end else begin
			for (int p = 0; p < NP; p++) begin
				if (!act[p]) begin
					cnt[p] <= '0;
				end else if (frm[p] && st[p] == PS_HUNT) begin
					cand[p] <= rx_ind[p];
					if (match[p]) begin
						cnt[p] <= (cnt[p] == MATCH_LAST) ? cnt[p] : cnt[p] + 3'h1;
					end else if (!line && pat_ok(rx_ind[p], inst)) begin
						cnt[p] <= 3'h1;
					end else begin
						cnt[p] <= '0;
					end
				end
			end
		end
	end

	// Lower pair wins when two pairs finish on one pattern together
	always_comb begin
		logic [IND_W-1:0] taken;
		taken = '0;
		for (int p = 0; p < NP; p++) begin
			if (done[p]) begin
				taken = taken | pat[p];
			end
		end
		for (int p = 0; p < NP; p++) begin
			go[p] = act[p] && frm[p] && st[p] == PS_HUNT && match[p] && cnt[p] == MATCH_LAST;
			if (!line) begin
				go[p] = go[p] && ((taken & rx_ind[p]) == '0);
				if (go[p]) begin
					taken = taken | rx_ind[p];
				end
			end
		end
	end

	// ----------------------------------------
	// Per pair identification state
	// ----------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			for (int p = 0; p < NP; p++) begin
				st[p] <= PS_WAIT;
				pat[p] <= '0;
			end
		end else begin
			for (int p = 0; p < NP; p++) begin
				unique case (st[p])
					PS_WAIT: begin
						if (act[p]) begin
							st[p] <= PS_HUNT;
						end
					end
					PS_HUNT: begin
						if (!act[p]) begin
							st[p] <= PS_WAIT;
						end else if (go[p]) begin
							st[p] <= PS_DONE;
							pat[p] <= line ? own[p] : rx_ind[p];
						end
					end
					PS_DONE: begin
						if (!act[p]) begin
							st[p] <= PS_WAIT;
						end
					end
				endcase
			end
		end
	end

	// Line side watches for the all-ones idle reply
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ones_seen <= '0;
		end else begin
			for (int p = 0; p < NP; p++) begin
				if (!act[p]) begin
					ones_seen[p] <= 1'b0;
				end else if (frm[p] && line) begin
					ones_seen[p] <= (rx_ind[p] & inst) == inst;
				end
			end
		end
	end

	// Indicator bits sent toward the far end
	always_comb begin
		for (int p = 0; p < NP; p++) begin
			if (line) begin
				tx_ind[p] = act[p] ? own[p] : '0;
			end else begin
				tx_ind[p] = done[p] ? pat[p] : inst;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			transparent <= 1'b0;
		end else begin
			transparent <= ctrl[CTRL_EN] && ((done | ~inst) == ALL_ONES);
		end
	end

	// ----------------------------------------
	// Deskew buffers
	// ----------------------------------------
	// Buffers refill only while transparent, so stale words never mix in
	for (genvar g = 0; g < NP; g++) begin : g_lane
		pid_fifo #(.W(DATA_W), .D(FIFO_DEPTH)) u_fifo (
			.clk(clk),
			.rstn(rstn),
			.flush(!transparent),
			.in_valid(rx_valid[g] && transparent),
			.in_data(rx_data[g]),
			.in_ready(fr[g]),
			.out_valid(fv[g]),
			.out_data(fdata[g]),
			.out_ready(fpop[g])
		);
	end

	assign all_v = (fv | ~inst) == ALL_ONES;
	assign some_v = (fv & inst) != '0;
	assign pop = transparent && all_v && (!core_valid || core_ready);
	assign fpop = {NP{pop}} & inst;
	// Flushed buffers look empty, so ready must not promise a take
	assign rx_ready = fr & {NP{transparent}};

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			core_valid <= 1'b0;
			core_data <= '0;
		end else if (pop) begin
			core_valid <= 1'b1;
			for (int p = 0; p < NP; p++) begin
				for (int l = 0; l < NP; l++) begin
					if (pat[p][l] && inst[p]) begin
						core_data[l*DATA_W +: DATA_W] <= fdata[p];
					end
				end
			end
		end else if (core_ready) begin
			core_valid <= 1'b0;
		end
	end

	// Skew beyond the buffer's reach is flagged, not corrected
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			skew_cnt <= '0;
		end else if (transparent && some_v && !all_v) begin
			skew_cnt <= (skew_cnt == SKEW_LAST) ? skew_cnt : skew_cnt + 1'b1;
		end else begin
			skew_cnt <= '0;
		end
	end

	// ----------------------------------------
	// Register port
	// ----------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctrl <= CTRL_RST;
			pairnum <= PAIRNUM_RST;
		end else if (wr && addr == REG_CTRL) begin
			ctrl <= wdata[2:0];
		end else if (wr && addr == REG_PAIRNUM) begin
			pairnum <= wdata[5:0];
		end
	end

	// Set beats a simultaneous write-one clear
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			skew_err <= 1'b0;
		end else if (skew_cnt == SKEW_LAST) begin
			skew_err <= 1'b1;
		end else if (wr && addr == REG_STATUS && wdata[ST_SKEW]) begin
			skew_err <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdata <= '0;
		end else if (rd) begin
			rdata <= '0;
			unique case (addr)
				REG_CTRL: rdata[2:0] <= ctrl;
				REG_PAIRNUM: rdata[5:0] <= pairnum;
				REG_STATUS: begin
					rdata[ST_DONE +: NP] <= done;
					rdata[ST_ONES +: NP] <= ones_seen;
					rdata[ST_XPAR] <= transparent;
					rdata[ST_SKEW] <= skew_err;
				end
				default: rdata <= '0;
			endcase
		end else begin
			rdata <= '0;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	for (genvar g = 0; g < NP; g++) begin : g_chk
		sequence s_sixth_hit;
			act[g] && frm[g] && st[g] == PS_HUNT && match[g] && cnt[g] == MATCH_LAST;
		endsequence
		a_cust_ones_idle: assert property (!line && !done[g] |-> tx_ind[g] == inst)
			else $error("customer side not sending all ones");
		a_cust_echo_hold: assert property (!line && done[g] && act[g] |=> done[g] && $stable(pat[g])
			&& tx_ind[g] == pat[g])
			else $error("echoed pattern changed");
		a_line_own_pat: assert property (line && act[g] |-> tx_ind[g] == own[g])
			else $error("line side pattern wrong");
		a_idle_no_count: assert property (!act[g] |=> cnt[g] == '0 && !done[g])
			else $error("counting while inactive");
		a_line_ack_six: assert property ((s_sixth_hit and line) |=> done[g])
			else $error("sixth match not acknowledged");
		a_done_needs_six: assert property ($rose(done[g]) |-> $past(cnt[g]) == MATCH_LAST
			&& $past(frm[g]))
			else $error("identified without six frames");
		a_count_restart: assert property (act[g] && frm[g] && st[g] == PS_HUNT && !match[g]
			|=> cnt[g] <= 3'h1)
			else $error("count not restarted");
	end

	a_unique_claim: assert property (!line && done[0] && done[1] |-> pat[0] != pat[1])
		else $error("same pattern on two pairs");
	a_xpar_all_done: assert property (transparent |-> $past((done | ~inst) == ALL_ONES))
		else $error("transparent before all pairs done");
	a_skew_sticky: assert property (skew_err && !(wr && addr == REG_STATUS) |=> skew_err)
		else $error("skew flag lost");
endmodule // pid_deskew

// ### tb/pid_far_model.sv
// Purpose: Far terminal across the parallel pairs
// Assumes: One frame every FP cycles, staggered per pair
// Notes: Mirror role echoes after six equal frames
`timescale 1ns/1ps
module pid_far_model #(
	parameter int FP = 8
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic three,
	input wire logic far_is_line,
	input wire logic [2:0] active,
	input wire logic [2:0][1:0] far_num,
	input wire logic [2:0][2:0] tx_ind,
	output logic [2:0] frm,
	output logic [2:0][2:0] rx_ind
);
	logic [7:0] tick;
	logic [2:0][2:0] seen, cnt, v;
	logic [2:0] lock, mask;
	assign mask = three ? 3'h7 : 3'h3;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tick <= '0;
			frm <= '0;
		end else begin
			tick <= (tick == FP - 1) ? '0 : tick + 8'h1;
			for (int p = 0; p < 3; p++) frm[p] <= (tick == p);
		end
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt <= '0;
			seen <= '0;
			lock <= '0;
		end else begin
			for (int p = 0; p < 3; p++) begin
				if (!active[p]) begin
					cnt[p] <= '0;
					lock[p] <= 1'b0;
				end else if (frm[p] && !lock[p]) begin
					if ($onehot(v[p]) && v[p] == seen[p]) begin
						cnt[p] <= cnt[p] + 3'h1;
						lock[p] <= (cnt[p] == 3'h5);
					end else begin
						seen[p] <= v[p];
						cnt[p] <= $onehot(v[p]) ? 3'h1 : 3'h0;
					end
				end
			end
		end
	end
	// Released pair shows a moving pattern, never a stale one
	always_comb begin
		for (int p = 0; p < 3; p++) begin
			v[p] = tx_ind[p] & mask;
			if (!active[p]) rx_ind[p] = tick[2:0];
			else if (far_is_line) rx_ind[p] = (3'h1 << (far_num[p] - 2'h1)) & mask;
			else rx_ind[p] = lock[p] ? seen[p] : mask;
		end
	end
endmodule // pid_far_model

// ### tb/tb.sv
// Purpose: Self-checking bench for pair identification and deskew
// Assumes: Far side is pid_far_model, frame every 8 cycles
// Notes: Line role uses pair numbers 3,1,2
`timescale 1ns/1ps
module tb;
	import pid_pkg::*;
	logic clk, rstn, wr, rd, core_valid, core_ready, transparent, drain, three, far_is_line;
	logic [3:0] addr;
	logic [31:0] wdata, rdata, st;
	logic [2:0] active, frm, rx_valid, rx_ready;
	logic [2:0][2:0] rx_ind, tx_ind;
	logic [2:0][7:0] rx_data, cur;
	logic [2:0][1:0] far_num;
	logic [23:0] core_data, exp;
	logic [7:0] q[3][$];
	int lane[3] = '{2, 0, 1};
	int num_errors, tests_run, t0, n, cyc;

	pid_deskew #(.DATA_W(8), .FIFO_DEPTH(8), .MAX_SKEW_CYC(40)) dut (.clk, .rstn, .addr, .wdata,
		.wr, .rd, .rdata, .active, .frm, .rx_ind, .tx_ind, .rx_data, .rx_valid, .rx_ready,
		.core_data, .core_valid, .core_ready, .transparent);
	pid_far_model #(.FP(8)) far (.clk, .rstn, .three, .far_is_line, .active, .far_num,
		.tx_ind, .frm, .rx_ind);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ----
	// Tasks
	// ----
	task chk(string s, logic [31:0] e, logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			$display("wrong value %s expected %h seen %h", s, e, g);
			num_errors++;
		end
	endtask
	task wreg(logic [3:0] a, logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask
	task rreg(logic [3:0] a);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		st = rdata;
	endtask
	task wait_xp(logic lv);
		for (n = 0; n < 400 && transparent !== lv; n++) @(posedge clk);
		chk("transparent", lv, transparent);
	endtask
	task feed(int p, int k);
		for (int i = 0; i < k; i++) begin
			rx_valid[p] <= 1'b1;
			rx_data[p] <= cur[p];
			@(posedge clk);
			if (rx_ready[p] === 1'b1) begin
				q[lane[p]].push_back(cur[p]);
				cur[p] = 8'($urandom);
			end
		end
		rx_valid[p] <= 1'b0;
	endtask
	task end_of_test();
		if (num_errors == 0 && tests_run > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	always @(posedge clk) begin
		cyc++;
		core_ready <= drain & 1'($urandom_range(1));
		if (core_valid === 1'b1 && core_ready === 1'b1) begin
			for (int l = 0; l < 3; l++) exp[l*8 +: 8] = q[l].pop_front();
			chk("core_data", exp, core_data);
		end
	end

	initial begin
		repeat (30000) @(posedge clk);
		num_errors++;
		end_of_test();
	end

	initial begin
		void'($urandom(32'hCFFCD2CC));
		{rstn, wr, rd, drain, far_is_line} = '0;
		{addr, wdata, active, rx_valid, rx_data, far_num} = '0;
		{num_errors, tests_run} = '0;
		three = 1'b1;
		cur = 24'($urandom);
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		rreg(REG_CTRL); chk("ctrl", 0, st);
		rreg(REG_PAIRNUM); chk("pairnum", 32'h39, st);
		rreg(4'hC); chk("unmapped", 0, st);
		wreg(REG_PAIRNUM, 32'h27);
		wreg(REG_CTRL, 32'h7);
		repeat (80) @(posedge clk);
		rreg(REG_STATUS); chk("done_idle", 0, st[2:0]);
		active <= 3'h7;
		t0 = cyc;
		@(posedge clk);
		for (int p = 0; p < 3; p++) chk("tx_ind", 3'h1 << lane[p], tx_ind[p]);
		repeat (24) @(posedge clk);
		rreg(REG_STATUS); chk("ones_seen", 7, st[5:3]);
		chk("early_xp", 0, st[6]);
		wait_xp(1'b1);
		chk("ident_delay", 1, cyc - t0 >= 80);
		rreg(REG_STATUS); chk("done", 7, st[2:0]);
		feed(1, 12); chk("fifo_fill", 8, q[0].size());
		repeat (50) @(posedge clk);
		rreg(REG_STATUS); chk("skew_err", 1, st[7]);
		feed(0, 8);
		feed(2, 8);
		wreg(REG_STATUS, 32'h80);
		rreg(REG_STATUS); chk("skew_clr", 0, st[7]);
		drain <= 1'b1;
		repeat (100) @(posedge clk);
		chk("drained", 0, q[0].size() + q[1].size() + q[2].size());
		drain <= 1'b0;
		active[1] <= 1'b0;
		repeat (3) @(posedge clk);
		chk("tx_off", 0, tx_ind[1]);
		rreg(REG_STATUS); chk("done_drop", 5, st[2:0]);
		chk("xp_drop", 0, st[6]);
		// Customer role, two pairs, duplicate pattern first
		rstn <= 1'b0;
		active <= 3'h0;
		@(posedge clk);
		rstn <= 1'b1;
		three <= 1'b0;
		far_is_line <= 1'b1;
		far_num <= 6'h05;
		@(posedge clk);
		wreg(REG_CTRL, 32'h1);
		repeat (40) @(posedge clk);
		rreg(REG_STATUS); chk("cust_idle", 0, st[2:0]);
		active <= 3'h3;
		repeat (2) @(posedge clk);
		chk("cust_ones", 3'h3, tx_ind[0]);
		repeat (100) @(posedge clk);
		rreg(REG_STATUS); chk("dup", 1, st[2:0]);
		chk("echo0", 3'h1, tx_ind[0]);
		chk("ones1", 3'h3, tx_ind[1]);
		far_num[1] <= 2'h2;
		wait_xp(1'b1);
		chk("echo1", 3'h2, tx_ind[1]);
		end_of_test();
	end
endmodule // tb
